/* rtl/adcdc_pkg.sv */
// Package with register map, field layouts and codes of the diagnostic and chop control bank.
package adcdc_pkg;
   // ***************************************************************
   // Register offsets and reset values
   // ***************************************************************
   localparam logic [6:0] ADDR_DIAG_RX = 7'h56;
   localparam logic [6:0] ADDR_DIAG_SEL = 7'h57;
   localparam logic [6:0] ADDR_MOD_DELAY = 7'h58;
   localparam logic [6:0] ADDR_CHOP = 7'h59;
   localparam logic [7:0] RST_DIAG_RX = 8'h00;
   localparam logic [7:0] RST_DIAG_SEL = 8'h00;
   localparam logic [7:0] RST_MOD_DELAY = 8'h02;
   localparam logic [7:0] RST_CHOP = 8'h0a;
   // ***************************************************************
   // Writable bit masks; all other bits read as zero
   // ***************************************************************
   localparam logic [7:0] MASK_DIAG_RX = 8'h33;
   localparam logic [7:0] MASK_DIAG_SEL = 8'h77;
   localparam logic [7:0] MASK_MOD_DELAY = 8'h0f;
   localparam logic [7:0] MASK_CHOP = 8'h0f;
   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int RX_CH0_BIT = 0;
   localparam int RX_CH1_BIT = 1;
   localparam int RX_CH2_BIT = 4;
   localparam int RX_CH3_BIT = 5;
   localparam int SEL_A_LSB = 0;
   localparam int SEL_B_LSB = 4;
   localparam int DEL_EN_LSB = 2;
   localparam int CHOP_A_LSB = 2;
   localparam int CHOP_B_LSB = 0;
   // ***************************************************************
   // Diagnostic voltage codes
   // ***************************************************************
   localparam logic [2:0] DIAG_OFF = 3'h0;
   localparam logic [2:0] DIAG_POS_FS = 3'h3;
   localparam logic [2:0] DIAG_NEG_FS = 3'h4;
   localparam logic [2:0] DIAG_ZERO = 3'h5;
   // Decoded diagnostic drive of one channel.
   typedef struct packed {
      logic pos_fs;
      logic neg_fs;
      logic zero;
   } adcdc_diag_s;
   // Register port request.
   typedef struct packed {
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } adcdc_req_s;
endpackage : adcdc_pkg

/* rtl/adcdc_regs.sv */
// Diagnostic, modulator delay and chopping control register bank.
`timescale 1ns/1ps
module adcdc_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire adcdc_pkg::adcdc_req_s req_i,
   output logic [7:0] rdata_o,
   input wire logic [3:0] chan_group_b_i,
   output adcdc_pkg::adcdc_diag_s [3:0] chan_diag_o,
   output logic [3:0] chan_delayed_clock_o,
   output logic [1:0] group_a_chop_rate_o,
   output logic [1:0] group_b_chop_rate_o
);
   // ***************************************************************
   // Register state
   // ***************************************************************
   logic [7:0] diag_receive_enable, next_diag_receive_enable;
   logic [7:0] diag_voltage_select, next_diag_voltage_select;
   logic [7:0] modulator_clock_delay, next_modulator_clock_delay;
   logic [7:0] chopping_rate, next_chopping_rate;
   logic [7:0] next_rdata;
   logic [3:0] rx;
   logic [2:0] group_a_diag_voltage;
   logic [2:0] group_b_diag_voltage;
   logic [1:0] delayed_modulator_clock_enable;

   // Decodes a three-bit selector into a drive; unlisted codes stay off.
   function automatic adcdc_pkg::adcdc_diag_s decode_sel(
      input logic [2:0] sel
   );
      adcdc_pkg::adcdc_diag_s d;
      d = '0;
      case (sel)
         adcdc_pkg::DIAG_POS_FS: d.pos_fs = 1'b1;
         adcdc_pkg::DIAG_NEG_FS: d.neg_fs = 1'b1;
         adcdc_pkg::DIAG_ZERO: d.zero = 1'b1;
         default: d = '0;
      endcase
      return d;
   endfunction : decode_sel

   // Write decode with masks and read mux.
   always_comb begin
      next_diag_receive_enable = diag_receive_enable;
      next_diag_voltage_select = diag_voltage_select;
      next_modulator_clock_delay = modulator_clock_delay;
      next_chopping_rate = chopping_rate;
      next_rdata = 8'h00;
      if (req_i.wr) begin
         case (req_i.addr)
            adcdc_pkg::ADDR_DIAG_RX: next_diag_receive_enable =
               req_i.wdata & adcdc_pkg::MASK_DIAG_RX;
            adcdc_pkg::ADDR_DIAG_SEL: next_diag_voltage_select =
               req_i.wdata & adcdc_pkg::MASK_DIAG_SEL;
            adcdc_pkg::ADDR_MOD_DELAY: next_modulator_clock_delay =
               req_i.wdata & adcdc_pkg::MASK_MOD_DELAY;
            adcdc_pkg::ADDR_CHOP: next_chopping_rate =
               req_i.wdata & adcdc_pkg::MASK_CHOP;
            default: next_rdata = 8'h00;
         endcase
      end
      case (req_i.addr)
         adcdc_pkg::ADDR_DIAG_RX: next_rdata = diag_receive_enable;
         adcdc_pkg::ADDR_DIAG_SEL: next_rdata = diag_voltage_select;
         adcdc_pkg::ADDR_MOD_DELAY: next_rdata = modulator_clock_delay;
         adcdc_pkg::ADDR_CHOP: next_rdata = chopping_rate;
         default: next_rdata = 8'h00;
      endcase
   end

   // Registers with their reset values.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         diag_receive_enable <= adcdc_pkg::RST_DIAG_RX;
         diag_voltage_select <= adcdc_pkg::RST_DIAG_SEL;
         modulator_clock_delay <= adcdc_pkg::RST_MOD_DELAY;
         chopping_rate <= adcdc_pkg::RST_CHOP;
         rdata_o <= 8'h00;
      end else begin
         diag_receive_enable <= next_diag_receive_enable;
         diag_voltage_select <= next_diag_voltage_select;
         modulator_clock_delay <= next_modulator_clock_delay;
         chopping_rate <= next_chopping_rate;
         rdata_o <= next_rdata;
      end
   end

   // ***************************************************************
   // Field extraction and channel steering
   // ***************************************************************
   assign rx = {diag_receive_enable[adcdc_pkg::RX_CH3_BIT],
                diag_receive_enable[adcdc_pkg::RX_CH2_BIT],
                diag_receive_enable[adcdc_pkg::RX_CH1_BIT],
                diag_receive_enable[adcdc_pkg::RX_CH0_BIT]};
   assign group_a_diag_voltage =
      diag_voltage_select[adcdc_pkg::SEL_A_LSB +: 3];
   assign group_b_diag_voltage =
      diag_voltage_select[adcdc_pkg::SEL_B_LSB +: 3];
   assign delayed_modulator_clock_enable =
      modulator_clock_delay[adcdc_pkg::DEL_EN_LSB +: 2];
   assign group_a_chop_rate_o = chopping_rate[adcdc_pkg::CHOP_A_LSB +: 2];
   assign group_b_chop_rate_o = chopping_rate[adcdc_pkg::CHOP_B_LSB +: 2];
   // Delayed clock: bit 0 for channels 0 and 1, bit 1 for 2 and 3.
   assign chan_delayed_clock_o = {{2{delayed_modulator_clock_enable[1]}},
      {2{delayed_modulator_clock_enable[0]}}};

   // Each receiving channel takes the voltage of its own group.
   always_comb begin
      for (int c = 0; c < 4; c++) begin
         chan_diag_o[c] = '0;
         if (rx[c]) begin
            chan_diag_o[c] = chan_group_b_i[c] ?
               decode_sel(group_b_diag_voltage) :
               decode_sel(group_a_diag_voltage);
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   // A reset cycle leaves every register and the read data at reset value.
   a_reset_values: assert property (
      @(posedge clk_i) rst_i |=>
      diag_receive_enable == 8'h00 && diag_voltage_select == 8'h00 &&
      modulator_clock_delay == 8'h02 && chopping_rate == 8'h0a &&
      rdata_o == 8'h00)
      else $error("reset value wrong");

   // A receive enable write reads back, masked, two edges later.
   a_rx_reads_back: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.wr && req_i.addr == adcdc_pkg::ADDR_DIAG_RX ##1
      req_i.addr == adcdc_pkg::ADDR_DIAG_RX && !req_i.wr |=>
      rdata_o == ($past(req_i.wdata, 2) & 8'h33))
      else $error("receive enable readback wrong");

   // Each mapped address returns its register one edge after it is seen.
   a_sel_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.addr == adcdc_pkg::ADDR_DIAG_SEL |=>
      rdata_o == $past(diag_voltage_select))
      else $error("select register readback wrong");
   a_delay_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.addr == adcdc_pkg::ADDR_MOD_DELAY |=>
      rdata_o == $past(modulator_clock_delay))
      else $error("delay register readback wrong");
   a_chop_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.addr == adcdc_pkg::ADDR_CHOP |=>
      rdata_o == $past(chopping_rate))
      else $error("chop register readback wrong");

   // Unmapped addresses read as zero and never disturb a register.
   a_unmapped_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.addr < adcdc_pkg::ADDR_DIAG_RX ||
      req_i.addr > adcdc_pkg::ADDR_CHOP |=> rdata_o == 8'h00)
      else $error("unmapped address read not zero");
   a_unmapped_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.wr && (req_i.addr < adcdc_pkg::ADDR_DIAG_RX ||
      req_i.addr > adcdc_pkg::ADDR_CHOP) |=>
      $stable(diag_receive_enable) && $stable(diag_voltage_select) &&
      $stable(modulator_clock_delay) && $stable(chopping_rate))
      else $error("unmapped write changed a register");

   // Bits without a field are never stored.
   a_rx_masked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (diag_receive_enable & 8'hcc) == 8'h00)
      else $error("reserved receive bit set");
   a_sel_masked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      diag_voltage_select[7] == 1'b0 && diag_voltage_select[3] == 1'b0)
      else $error("reserved select bit set");
   a_chop_masked: assert property (
      @(posedge clk_i) disable iff (rst_i)
      chopping_rate[7:4] == 4'h0 && modulator_clock_delay[7:4] == 4'h0)
      else $error("reserved chop or delay bit set");

   // A channel that does not receive is never driven.
   a_no_rx_no_diag: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rx[0] || chan_diag_o[0] == 3'h0) &&
      (rx[1] || chan_diag_o[1] == 3'h0) &&
      (rx[2] || chan_diag_o[2] == 3'h0) &&
      (rx[3] || chan_diag_o[3] == 3'h0))
      else $error("diagnostic without receive");

   // At most one diagnostic voltage reaches a channel at a time.
   a_drive_onehot: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $onehot0(chan_diag_o[0]) && $onehot0(chan_diag_o[1]) &&
      $onehot0(chan_diag_o[2]) && $onehot0(chan_diag_o[3]))
      else $error("more than one diagnostic drive");

   // Group selectors reach the channels of their own group.
   a_group_a_off: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !chan_group_b_i[1] && group_a_diag_voltage == 3'h0 |->
      chan_diag_o[1] == 3'h0)
      else $error("group a off still drives");
   a_group_b_pos: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx[3] && chan_group_b_i[3] && group_b_diag_voltage == 3'h3 |->
      chan_diag_o[3].pos_fs && !chan_diag_o[3].zero)
      else $error("group b positive drive wrong");
   a_group_b_neg: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx[2] && chan_group_b_i[2] && group_b_diag_voltage == 3'h4 |->
      chan_diag_o[2] == 3'h2)
      else $error("group b negative drive wrong");
   a_group_a_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      rx[0] && !chan_group_b_i[0] && group_a_diag_voltage == 3'h5 |->
      chan_diag_o[0].zero && !chan_diag_o[0].neg_fs)
      else $error("group a zero drive wrong");

   // Delayed clock enable bit 3 serves channels 2 and 3, bit 2 the others.
   a_delay_ch23: assert property (
      @(posedge clk_i) disable iff (rst_i)
      chan_delayed_clock_o[3:2] == {2{modulator_clock_delay[3]}})
      else $error("delayed clock mapping wrong");
   a_delay_ch01: assert property (
      @(posedge clk_i) disable iff (rst_i)
      chan_delayed_clock_o[1:0] == {2{modulator_clock_delay[2]}})
      else $error("delayed clock mapping wrong");

   // A chop write shows on both group outputs at the next edge.
   a_chop_write: assert property (
      @(posedge clk_i) disable iff (rst_i)
      req_i.wr && req_i.addr == adcdc_pkg::ADDR_CHOP |=>
      group_a_chop_rate_o == $past(req_i.wdata[3:2]) &&
      group_b_chop_rate_o == $past(req_i.wdata[1:0]))
      else $error("chop rate write lost");
endmodule : adcdc_regs

/* verification/adc_diag_chop_ctrl_regs_bench.sv */
// Self-checking testbench of the diagnostic and chop control register bank.
`timescale 1ns/1ps
module adc_diag_chop_ctrl_regs_bench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   adcdc_pkg::adcdc_req_s req_i = '0;
   logic [7:0] rdata_o;
   logic [3:0] chan_group_b_i = 4'h0;
   adcdc_pkg::adcdc_diag_s [3:0] chan_diag_o;
   logic [3:0] chan_delayed_clock_o;
   logic [1:0] group_a_chop_rate_o;
   logic [1:0] group_b_chop_rate_o;
   int n_errors = 0;
   int samples_checked = 0;
   // ***************************************************************
   // Clock, device and shared tasks
   // ***************************************************************
   // The clock toggles every half period of 25 ns.
   always #25 clk_i = ~clk_i;
   adcdc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
      .rdata_o(rdata_o), .chan_group_b_i(chan_group_b_i),
      .chan_diag_o(chan_diag_o), .chan_delayed_clock_o(chan_delayed_clock_o),
      .group_a_chop_rate_o(group_a_chop_rate_o),
      .group_b_chop_rate_o(group_b_chop_rate_o));
   // Compares one value with case equality and counts the outcome.
   task automatic compare(input string what, input logic [11:0] exp,
                          input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : compare
   // One write pulse; the request is held across exactly one taking edge.
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      @(posedge clk_i);
      #5;
      req_i = {1'b1, addr, data};
      @(posedge clk_i);
      #5;
      req_i.wr = 1'b0;
   endtask : write_reg
   // Read data is registered; it is judged at the stimulus delay after the
   // edge that loads it, while it still stands.
   task automatic read_reg(input logic [6:0] addr, input logic [7:0] exp);
      @(posedge clk_i);
      #5;
      req_i = {1'b0, addr, 8'h00};
      @(posedge clk_i);
      #5;
      compare($sformatf("register %h", addr), {4'h0, exp}, {4'h0, rdata_o});
   endtask : read_reg
   // Expected one-hot drive for a selector code; unused codes drive nothing.
   function automatic logic [2:0] drive_of(input logic [2:0] code);
      case (code)
         3'h3: drive_of = 3'h4;
         3'h4: drive_of = 3'h2;
         3'h5: drive_of = 3'h1;
         default: drive_of = 3'h0;
      endcase
   endfunction : drive_of
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   // Reset for ten cycles, then check reset values and idle outputs.
   task automatic check_reset();
      rst_i = 1'b1;
      repeat (10) @(posedge clk_i);
      #5;
      rst_i = 1'b0;
      compare("outputs after reset", 12'h00a,
              {4'h0, chan_delayed_clock_o, group_a_chop_rate_o,
               group_b_chop_rate_o});
      compare("diagnostic drive after reset", 12'h000, chan_diag_o);
      read_reg(7'h56, 8'h00);
      read_reg(7'h57, 8'h00);
      read_reg(7'h58, 8'h02);
      read_reg(7'h59, 8'h0a);
   endtask : check_reset
   // All ones into each register and one unmapped place; only fields stay.
   // The fixed delay field is always written as binary 10.
   task automatic check_masks();
      logic [6:0] addrs [5] = '{7'h56, 7'h57, 7'h58, 7'h59, 7'h55};
      logic [7:0] datas [5] = '{8'hff, 8'hff, 8'hfe, 8'hff, 8'hff};
      logic [7:0] exps [5] = '{8'h33, 8'h77, 8'h0e, 8'h0f, 8'h00};
      for (int i = 0; i < 5; i++) begin
         write_reg(addrs[i], datas[i]);
         read_reg(addrs[i], exps[i]);
      end
   endtask : check_masks
   // Every selector code in both groups, with two channel groupings.
   task automatic check_diag();
      logic [11:0] exp;
      logic [2:0] b;
      // Precharge buffers sit outside this bank and are taken as enabled.
      write_reg(7'h56, 8'h33);
      for (int g = 0; g < 2; g++) begin
         chan_group_b_i = g ? 4'h5 : 4'ha;
         for (int a = 0; a < 8; a++) begin
            b = 3'(7 - a);
            write_reg(7'h57, {1'b0, b, 1'b0, 3'(a)});
            for (int c = 0; c < 4; c++) begin
               exp[c*3+:3] = chan_group_b_i[c] ? drive_of(b) : drive_of(3'(a));
            end
            compare("diagnostic drive", exp, chan_diag_o);
         end
      end
      // Channels 1 and 2 stop receiving; channel 0 is in group B, 3 in A.
      write_reg(7'h57, 8'h00);
      write_reg(7'h56, 8'h21);
      write_reg(7'h57, 8'h35);
      compare("partial receive", 12'h204, chan_diag_o);
   endtask : check_diag
   // Each delayed clock enable code, with the fixed field written as 10.
   task automatic check_delay();
      logic [1:0] d;
      for (int i = 0; i < 4; i++) begin
         d = 2'(i);
         write_reg(7'h58, {4'h0, d, 2'b10});
         compare("delayed clock", {8'h00, d[1], d[1], d[0], d[0]},
                 {8'h00, chan_delayed_clock_o});
         read_reg(7'h58, {4'h0, d, 2'b10});
      end
   endtask : check_delay
   // Chop rate codes 01 and 10 in each group, in both orders.
   task automatic check_chop();
      logic [7:0] vals [2] = '{8'h06, 8'h09};
      for (int i = 0; i < 2; i++) begin
         write_reg(7'h59, vals[i]);
         compare("chop rates", {8'h00, vals[i][3:0]},
                 {8'h00, group_a_chop_rate_o, group_b_chop_rate_o});
         read_reg(7'h59, vals[i]);
      end
   endtask : check_chop
   // ***************************************************************
   // Verdict, main sequence and watchdog
   // ***************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks made %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   // Runs the scenarios in turn, with a second reset in mid-run.
   initial begin
      check_reset();
      check_masks();
      check_reset();
      check_diag();
      check_delay();
      check_chop();
      print_verdict();
   end
   // The scenarios need about 120 cycles; two thousand cut a hang.
   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
endmodule : adc_diag_chop_ctrl_regs_bench
